// [design/swdt_params.svh]
// Constants of the system watchdog timer
// Operation
// - Watchdog starts enabled and counting after every application reset.
// - Dedicated disable and enable instructions stop or restart it until a prewarning is raised.
// - Missed service: prewarning interrupt first, reset request afterwards.
// - Sixteen-bit counter advanced by a system clock prescaler of 16384 or 256.
// - Counter start value comes from a programmable reload value.
// - Each service accepted before prewarning loads the reload value and clears the prescaler together.
// - Default reload and prescaler give about 6.5 ms at a 10 MHz clock.
`ifndef SWDT_PARAMS_SVH
`define SWDT_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SWDT_CNT_W        16
`define SWDT_PRE_LONG_W   14
`define SWDT_PRE_SHORT_W  8

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define SWDT_CNT_MAX      16'hFFFF
`define SWDT_CNT_ONE      16'h0001
`define SWDT_GAP_ZERO     16'h0000
// Four long ticks: 4 x 16384 clocks, 6.55 ms at 10 MHz
`define SWDT_DEF_RELOAD   16'hFFFC
`define SWDT_DEF_SHORT    1'b0
`define SWDT_GAP_CYCLES   16'h0100

`endif

// [design/swdt_pkg.sv]
// Types of the system watchdog timer
`include "swdt_params.svh"

package swdt_pkg;

   // ----------------------------------------------------------------
   // Watchdog modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN,
      ST_STOP,
      ST_PREWARN,
      ST_RESET
   } swdt_mode_t;

   // ----------------------------------------------------------------
   // Top state
   // ----------------------------------------------------------------
   typedef struct packed {
      swdt_mode_t                 mode;
      logic                       running;
      logic [`SWDT_CNT_W-1:0]     count;
      logic [`SWDT_CNT_W-1:0]     reload;
      logic                       short_presc;
      logic [15:0]                gap;
      logic                       prewarn;
      logic                       rst_req;
   } swdt_state_t;

endpackage

// [design/swdt_prescaler.sv]
// Watchdog prescaler, divide by 2**LONG_W or 2**SHORT_W
`timescale 1ns/1ps
`include "swdt_params.svh"

module swdt_prescaler #(
   parameter int LONG_W  = `SWDT_PRE_LONG_W,
   parameter int SHORT_W = `SWDT_PRE_SHORT_W
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic clear,
   input  wire logic run,
   input  wire logic short_sel,
   output logic      tick
);

   typedef struct packed {
      logic [LONG_W-1:0] cnt;
      logic              tick;
   } swdt_pre_t;

   swdt_pre_t st_q;
   swdt_pre_t st_d;

   if (SHORT_W < 1 || SHORT_W >= LONG_W) begin : g_width_chk
      $error("Prescaler widths out of range");
   end

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (clear) begin
         st_d.cnt = '0;
      end else if (run) begin
         st_d.cnt = st_q.cnt + {{(LONG_W-1){1'b0}}, 1'b1};
         if (short_sel) begin
            st_d.tick = &st_q.cnt[SHORT_W-1:0];
         end else begin
            st_d.tick = &st_q.cnt;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick = st_q.tick;

endmodule // swdt_prescaler

// [design/swdt_top.sv]
// System watchdog timer top
`timescale 1ns/1ps
`include "swdt_params.svh"

module swdt_top #(
   parameter logic [15:0] GAP_CYCLES = `SWDT_GAP_CYCLES
) (
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic                   service,
   input  wire logic                   watchdog_disable_instruction,
   input  wire logic                   watchdog_enable_instruction,
   input  wire logic                   cfg_wr,
   input  wire logic [`SWDT_CNT_W-1:0] watchdog_reload_value,
   input  wire logic                   cfg_short_presc,
   output logic                        prewarn_irq,
   output logic                        reset_req,
   output logic                        running,
   output logic [`SWDT_CNT_W-1:0]      count
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam swdt_pkg::swdt_state_t ST_RST = '{
      mode:        swdt_pkg::ST_RUN,
      running:     1'b1,
      count:       `SWDT_DEF_RELOAD,
      reload:      `SWDT_DEF_RELOAD,
      short_presc: `SWDT_DEF_SHORT,
      gap:         `SWDT_GAP_ZERO,
      prewarn:     1'b0,
      rst_req:     1'b0
   };

   swdt_pkg::swdt_state_t st_q;
   swdt_pkg::swdt_state_t st_d;
   logic                  tick;
   logic                  svc_ok;
   logic                  dis_only;
   logic                  en_only;

   if (GAP_CYCLES < 16'h0002) begin : g_gap_chk
      $error("GAP_CYCLES must be at least two");
   end

   assign dis_only = watchdog_disable_instruction && !watchdog_enable_instruction;
   assign en_only  = watchdog_enable_instruction && !watchdog_disable_instruction;
   assign svc_ok   = service &&
                     (st_q.mode == swdt_pkg::ST_RUN || st_q.mode == swdt_pkg::ST_STOP);

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   swdt_prescaler #(
      .LONG_W  (`SWDT_PRE_LONG_W),
      .SHORT_W (`SWDT_PRE_SHORT_W)
   ) u_presc (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .clear     (svc_ok),
      .run       (st_q.mode == swdt_pkg::ST_RUN),
      .short_sel (st_q.short_presc),
      .tick      (tick)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d         = st_q;
      st_d.prewarn = 1'b0;
      if (cfg_wr) begin
         st_d.reload      = watchdog_reload_value;
         st_d.short_presc = cfg_short_presc;
      end
      unique case (st_q.mode)
         swdt_pkg::ST_RUN: begin
            if (dis_only) begin
               st_d.mode = swdt_pkg::ST_STOP;
            end
            if (svc_ok) begin
               st_d.count = st_q.reload;
            end else if (tick) begin
               st_d.count = st_q.count + `SWDT_CNT_ONE;
               if (st_q.count == `SWDT_CNT_MAX) begin
                  st_d.mode    = swdt_pkg::ST_PREWARN;
                  st_d.prewarn = 1'b1;
                  st_d.gap     = `SWDT_GAP_ZERO;
               end
            end
         end
         swdt_pkg::ST_STOP: begin
            if (svc_ok) begin
               st_d.count = st_q.reload;
            end
            if (en_only) begin
               st_d.mode = swdt_pkg::ST_RUN;
            end
         end
         swdt_pkg::ST_PREWARN: begin
            st_d.gap = st_q.gap + `SWDT_CNT_ONE;
            if (st_q.gap == GAP_CYCLES - `SWDT_CNT_ONE) begin
               st_d.mode    = swdt_pkg::ST_RESET;
               st_d.rst_req = 1'b1;
            end
         end
         swdt_pkg::ST_RESET: begin
            st_d.rst_req = 1'b1;
         end
      endcase
      st_d.running = (st_d.mode == swdt_pkg::ST_RUN);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prewarn_irq = st_q.prewarn;
   assign reset_req   = st_q.rst_req;
   assign running     = st_q.running;
   assign count       = st_q.count;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_reset_armed:
   assert property (
      @(posedge clock)
      sys_rst |=> running && !reset_req && !prewarn_irq
   ) else $error("Watchdog not armed after reset");

   a_default_cfg:
   assert property (
      @(posedge clock)
      sys_rst |=> st_q.reload == `SWDT_DEF_RELOAD &&
                  st_q.short_presc == `SWDT_DEF_SHORT
   ) else $error("Default reload or prescaler wrong");

   a_disable_stop:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      st_q.mode == swdt_pkg::ST_RUN && dis_only &&
      !(tick && !svc_ok && count == `SWDT_CNT_MAX)
      |=> !running ##1 (!running || $past(en_only))
   ) else $error("Disable did not stop watchdog");

   a_enable_run:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      st_q.mode == swdt_pkg::ST_STOP && en_only |=> running
   ) else $error("Enable did not restart watchdog");

   a_warn_first:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      prewarn_irq |-> !reset_req ##1 (!prewarn_irq && !reset_req)
   ) else $error("Reset request not preceded by prewarning");

   a_rst_after_warn:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      $rose(reset_req) |-> $past(st_q.mode) == swdt_pkg::ST_PREWARN &&
                           $past(st_q.gap) == GAP_CYCLES - `SWDT_CNT_ONE
   ) else $error("Reset request without prewarning interval");

   a_overflow_warn:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      st_q.mode == swdt_pkg::ST_RUN && tick && !svc_ok && count == `SWDT_CNT_MAX
      |=> prewarn_irq && count == 16'h0000
   ) else $error("Overflow did not raise prewarning");

   a_count_step:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      st_q.mode == swdt_pkg::ST_RUN && !svc_ok && !tick |=> $stable(count)
   ) else $error("Counter moved without prescaler tick");

   a_tick_spacing:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      tick |=> !tick [*8]
   ) else $error("Prescaler ticks too close together");

   a_service_load:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      svc_ok |=> count == $past(st_q.reload) && !tick
   ) else $error("Service did not reload and clear prescaler");

   a_hold_stopped:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      st_q.mode == swdt_pkg::ST_STOP && !svc_ok |=> $stable(count)
   ) else $error("Counter moved while disabled");

   a_reload_store:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      cfg_wr |=> st_q.reload == $past(watchdog_reload_value)
   ) else $error("Reload value not stored");

   a_both_ignored:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      watchdog_disable_instruction && watchdog_enable_instruction &&
      (st_q.mode == swdt_pkg::ST_RUN || st_q.mode == swdt_pkg::ST_STOP) &&
      !(tick && !svc_ok && count == `SWDT_CNT_MAX)
      |=> $stable(running)
   ) else $error("Simultaneous disable and enable changed the mode");

   a_req_held:
   assert property (
      @(posedge clock) disable iff (sys_rst)
      reset_req |=> reset_req && !running
   ) else $error("Reset request dropped before reset");

endmodule // swdt_top

// [sim/tb.sv]
// Self-checking testbench of the system watchdog timer
`timescale 1ns/1ps
`include "swdt_params.svh"

module tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [15:0] GAP = 16'h0004;
   logic        clock                        = 1'b0;
   logic        sys_rst                      = 1'b1;
   logic        service                      = 1'b0;
   logic        watchdog_disable_instruction = 1'b0;
   logic        watchdog_enable_instruction  = 1'b0;
   logic        cfg_wr                       = 1'b0;
   logic [15:0] watchdog_reload_value        = 16'h0000;
   logic        cfg_short_presc              = 1'b0;
   logic        prewarn_irq;
   logic        reset_req;
   logic        running;
   logic [15:0] count;
   int          n_mismatch                   = 0;
   int          num_checks                   = 0;

   always #2.5 clock = ~clock;

   swdt_top #(.GAP_CYCLES(GAP)) swdt_top_i (
      .clock                        (clock),
      .sys_rst                      (sys_rst),
      .service                      (service),
      .watchdog_disable_instruction (watchdog_disable_instruction),
      .watchdog_enable_instruction  (watchdog_enable_instruction),
      .cfg_wr                       (cfg_wr),
      .watchdog_reload_value        (watchdog_reload_value),
      .cfg_short_presc              (cfg_short_presc),
      .prewarn_irq                  (prewarn_irq),
      .reset_req                    (reset_req),
      .running                      (running),
      .count                        (count)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clock);
         #1;
      end
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic do_reset;
      sys_rst = 1'b1;
      step(5);
      sys_rst = 1'b0;
   endtask

   task automatic cfg(input logic [15:0] rel, input logic sh);
      cfg_wr = 1'b1;
      watchdog_reload_value = rel;
      cfg_short_presc = sh;
      step(1);
      cfg_wr = 1'b0;
   endtask

   task automatic svc;
      service = 1'b1;
      step(1);
      service = 1'b0;
   endtask

   task automatic wait_prewarn(input int lim, output int n);
      n = 0;
      while (prewarn_irq !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      do_reset;
      chk("running", 16'h0001, {15'h0000, running});
      chk("count", `SWDT_DEF_RELOAD, count);
      chk("prewarn", 16'h0000, {15'h0000, prewarn_irq});
      chk("reset_req", 16'h0000, {15'h0000, reset_req});
      $display("test reset done");
   endtask

   task automatic t_service;
      int n;
      cfg(16'hFFF0, 1'b1);
      svc;
      chk("count", 16'hFFF0, count);
      step(200);
      svc;
      step(250);
      chk("count", 16'hFFF0, count);
      n = 0;
      while (count === 16'hFFF0 && n < 12) begin
         step(1);
         n++;
      end
      chk("count", 16'hFFF1, count);
      chk("tick delay", 16'h0007, n[15:0]);
      $display("test service done");
   endtask

   task automatic t_stop;
      logic [15:0] c;
      watchdog_disable_instruction = 1'b1;
      step(1);
      watchdog_disable_instruction = 1'b0;
      c = count;
      chk("running", 16'h0000, {15'h0000, running});
      step(300);
      chk("count", c, count);
      svc;
      step(300);
      chk("count", 16'hFFF0, count);
      watchdog_enable_instruction = 1'b1;
      step(1);
      watchdog_enable_instruction = 1'b0;
      chk("running", 16'h0001, {15'h0000, running});
      step(270);
      chk("count", 16'hFFF1, count);
      watchdog_disable_instruction = 1'b1;
      watchdog_enable_instruction = 1'b1;
      step(1);
      watchdog_disable_instruction = 1'b0;
      watchdog_enable_instruction = 1'b0;
      chk("running", 16'h0001, {15'h0000, running});
      $display("test stop done");
   endtask

   task automatic t_overflow;
      int n;
      cfg(16'hFFFE, 1'b1);
      svc;
      wait_prewarn(800, n);
      chk("overflow delay", 16'h0201, n[15:0]);
      chk("prewarn", 16'h0001, {15'h0000, prewarn_irq});
      chk("count", 16'h0000, count);
      chk("reset_req", 16'h0000, {15'h0000, reset_req});
      watchdog_disable_instruction = 1'b1;
      step(1);
      watchdog_disable_instruction = 1'b0;
      chk("prewarn", 16'h0000, {15'h0000, prewarn_irq});
      step(int'(GAP) - 2);
      chk("reset_req", 16'h0000, {15'h0000, reset_req});
      step(1);
      chk("reset_req", 16'h0001, {15'h0000, reset_req});
      step(5);
      chk("reset_req", 16'h0001, {15'h0000, reset_req});
      do_reset;
      chk("reset_req", 16'h0000, {15'h0000, reset_req});
      $display("test overflow done");
   endtask

   task automatic t_default;
      int n;
      step(1);
      do_reset;
      wait_prewarn(70000, n);
      chk("interval", 16'h0001, {15'h0000, (n == 65537)});
      chk("count", 16'h0000, count);
      $display("test default interval done");
   endtask

   // ----------------------------------------------------------------
   // Verdict
   // ----------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #(5 * 90000);
      n_mismatch++;
      wrap_up;
   end

   initial begin
      t_reset;
      t_service;
      t_stop;
      t_overflow;
      t_default;
      wrap_up;
   end
endmodule // tb
